/* include/mcr_pkg.sv */
// mcr_pkg: offset, field layout, reset values and chop modes of the mode control register
package mcr_pkg;
  localparam logic [7:0] MCR_MODE_OFFSET = 8'h70;
  localparam int MCR_CHOP_HI = 5;
  localparam int MCR_CHOP_LO = 4;
  localparam int MCR_FORCE_ON_BIT = 3;
  localparam int MCR_FORCE_OFF_BIT = 2;
  localparam int MCR_REF_OUT_BIT = 1;
  localparam int MCR_EXT_REF_BIT = 0;
  localparam logic [1:0] MCR_RSVD_VALUE = 2'h2;
  localparam logic [1:0] MCR_CHOP_RESET = 2'h0;
  localparam logic MCR_FORCE_ON_RESET = 1'b0;
  localparam logic MCR_FORCE_OFF_RESET = 1'b1;
  localparam logic MCR_REF_OUT_RESET = 1'b0;
  localparam logic MCR_EXT_REF_RESET = 1'b0;
  localparam int MCR_RSVD_HI = 7;
  localparam int MCR_RSVD_LO = 6;
  localparam logic MCR_PUMP_RESET = 1'b0;
  localparam logic MCR_PIN_RESET = 1'b0;
  localparam logic [3:0] MCR_ELEM_CNT_RESET = 4'h1;
  localparam logic [2:0] MCR_ELEM_CNT_W = 3'h3;
  typedef enum logic [1:0] {
    MCR_CHOP_LOW = 2'h0,
    MCR_CHOP_HIGH = 2'h1,
    MCR_CHOP_EACH = 2'h2,
    MCR_CHOP_HALF = 2'h3
  } mcr_chop_type;
endpackage

/* logic/mcr_chop_gen.sv */
// mcr_chop_gen: bandgap chop state sequencer across the elementary conversions
`timescale 1ns/1ps
module mcr_chop_gen
  import mcr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // control
  input wire logic [1:0] chop_mode_in,
  input wire logic conv_start_in,
  input wire logic elem_done_in,
  // state
  output logic chop_state_out
);
  logic chop_ff;
  logic nxt_chop;
  logic half_ff;
  logic nxt_half;
  mcr_chop_type mode;
  assign mode = mcr_chop_type'(chop_mode_in);

  // toggling restarts from 0 at each conversion start so both ends agree on phase
  always_comb begin
    nxt_chop = chop_ff;
    nxt_half = half_ff;
    unique case (mode)
      MCR_CHOP_LOW: begin
        nxt_chop = 1'b0; // see R3
      end
      MCR_CHOP_HIGH: begin
        nxt_chop = 1'b1; // see R3
      end
      MCR_CHOP_EACH: begin
        if (conv_start_in) begin
          nxt_chop = 1'b0;
        end else if (elem_done_in) begin
          nxt_chop = ~chop_ff; // see R2
        end
      end
      MCR_CHOP_HALF: begin
        if (conv_start_in) begin
          nxt_chop = 1'b0;
          nxt_half = 1'b0;
        end else if (elem_done_in) begin
          nxt_half = ~half_ff;
          if (half_ff) begin
            nxt_chop = ~chop_ff; // see R1
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chop_ff <= 1'b0;
      half_ff <= 1'b0;
    end else begin
      chop_ff <= nxt_chop;
      half_ff <= nxt_half;
    end
  end

  assign chop_state_out = chop_ff;

  ////////////////////////////////////////////////////////////////////////////////
  a_chop_low_fixed: assert property (@(posedge clk_in) disable iff (srst_in) // see R3
    (mode == MCR_CHOP_LOW) |=> !chop_state_out)
    else $error("chop state not low in forced-low mode");
  a_chop_high_fixed: assert property (@(posedge clk_in) disable iff (srst_in) // see R3
    (mode == MCR_CHOP_HIGH) |=> chop_state_out)
    else $error("chop state not high in forced-high mode");
  a_chop_each_toggle: assert property (@(posedge clk_in) disable iff (srst_in) // see R2
    (mode == MCR_CHOP_EACH && elem_done_in && !conv_start_in) |=> (chop_state_out != $past(chop_state_out)))
    else $error("chop did not toggle per elementary conversion");
  a_chop_half_hold: assert property (@(posedge clk_in) disable iff (srst_in) // see R1
    (mode == MCR_CHOP_HALF && elem_done_in && !conv_start_in && !half_ff) |=> $stable(chop_state_out))
    else $error("chop toggled on odd elementary conversion");
  c_chop_each: cover property (@(posedge clk_in) mode == MCR_CHOP_EACH && elem_done_in);
  c_chop_half: cover property (@(posedge clk_in) mode == MCR_CHOP_HALF && elem_done_in && half_ff);
endmodule

/* logic/mcr_mode_ctrl.sv */
// mcr_mode_ctrl: mode control register, pump forcing, reference pin routing and chop control
`timescale 1ns/1ps
// Operation
// R1: code 11 toggles chop every two elementary conversions
// R2: code 10 toggles chop every elementary conversion
// R3: code 01 holds chop 1; 00 holds 0
// R4: force-on turns pump on, beats force-off
// R5: force-off resets 1, keeps pump off
// R6: reference output bit drives reference onto pin 0
// R7: external reference bit takes reference from pin 1
// R8: pin 1 drives only if output, no external reference
// R9: pin 0 drives only if output, no reference output
// R10: elementary conversions equal two to count field
// R11: top bits read 1 then 0, unwritable
module mcr_mode_ctrl
  import mcr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port from the serial host interface
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // conversion sequencing from the converter
  input wire logic [1:0] elem_count_exponent_in,
  input wire logic conv_start_in,
  input wire logic elem_done_in,
  // pin control from the gpio registers
  input wire logic pin0_direction_in,
  input wire logic pin1_direction_in,
  input wire logic pin0_output_value_in,
  input wire logic pin1_output_value_in,
  // general pins, enable low while driving
  output logic general_pin_0_out,
  output logic general_pin_0_oe_n_out,
  output logic general_pin_1_out,
  output logic general_pin_1_oe_n_out,
  // analog controls
  output logic pump_enable_out,
  output logic ref_out_on_pin0_out,
  output logic ext_ref_in_pin1_out,
  output logic chop_state_out,
  output logic [3:0] elem_count_out
);
  logic [1:0] chop_mode_ff;
  logic pump_force_on_ff;
  logic pump_force_off_ff;
  logic ref_out_on_pin0_ff;
  logic ext_ref_in_pin1_ff;
  logic pin0_drive_ff;
  logic pin0_val_ff;
  logic pin1_drive_ff;
  logic pin1_val_ff;
  logic pump_ff;
  logic [3:0] elem_count_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  // a shift gives the power of two; a 2-bit exponent keeps the result inside 4 bits
  function automatic logic [3:0] elem_count_of(input logic [1:0] exponent);
    elem_count_of = 4'h1 << exponent;
  endfunction

  wire sel_mode = (reg_addr_in == MCR_MODE_OFFSET);
  wire wr_mode = reg_wr_in && sel_mode;
  wire nxt_pump = pump_force_on_ff || !pump_force_off_ff; // see R4 see R5
  wire nxt_pin0_drive = pin0_direction_in && !ref_out_on_pin0_ff; // see R9
  wire nxt_pin1_drive = pin1_direction_in && !ext_ref_in_pin1_ff; // see R8
  wire [3:0] nxt_elem_count = elem_count_of(elem_count_exponent_in); // see R10
  wire [1:0] wdata_chop = reg_wdata_in[MCR_CHOP_HI:MCR_CHOP_LO];
  wire wdata_force_on = reg_wdata_in[MCR_FORCE_ON_BIT];
  wire wdata_force_off = reg_wdata_in[MCR_FORCE_OFF_BIT];
  wire wdata_ref_out = reg_wdata_in[MCR_REF_OUT_BIT];
  wire wdata_ext_ref = reg_wdata_in[MCR_EXT_REF_BIT];
  wire [7:0] mode_image = {MCR_RSVD_VALUE, chop_mode_ff, pump_force_on_ff, pump_force_off_ff,
                           ref_out_on_pin0_ff, ext_ref_in_pin1_ff}; // see R11

  assign reg_hit_out = sel_mode;
  assign reg_rdata_out = sel_mode ? mode_image : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // register; reserved bits 7:6 have no storage so writes cannot land there
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chop_mode_ff <= MCR_CHOP_RESET;
      pump_force_on_ff <= MCR_FORCE_ON_RESET;
      pump_force_off_ff <= MCR_FORCE_OFF_RESET;
      ref_out_on_pin0_ff <= MCR_REF_OUT_RESET;
      ext_ref_in_pin1_ff <= MCR_EXT_REF_RESET;
    end else if (wr_mode) begin
      chop_mode_ff <= wdata_chop;
      pump_force_on_ff <= wdata_force_on;
      pump_force_off_ff <= wdata_force_off;
      ref_out_on_pin0_ff <= wdata_ref_out; // see R6
      ext_ref_in_pin1_ff <= wdata_ext_ref; // see R7
    end
  end

  // outputs registered; pin and pump follow the register one cycle later
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pump_ff <= MCR_PUMP_RESET;
    end else begin
      pump_ff <= nxt_pump;
    end
  end

  // gate and value move together so a driven pin never shows a stale value
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin0_drive_ff <= MCR_PIN_RESET;
      pin0_val_ff <= MCR_PIN_RESET;
    end else begin
      pin0_drive_ff <= nxt_pin0_drive; // see R9
      pin0_val_ff <= pin0_output_value_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin1_drive_ff <= MCR_PIN_RESET;
      pin1_val_ff <= MCR_PIN_RESET;
    end else begin
      pin1_drive_ff <= nxt_pin1_drive; // see R8
      pin1_val_ff <= pin1_output_value_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      elem_count_ff <= MCR_ELEM_CNT_RESET;
    end else begin
      elem_count_ff <= nxt_elem_count;
    end
  end

  assign pump_enable_out = pump_ff;
  assign ref_out_on_pin0_out = ref_out_on_pin0_ff; // see R6
  assign ext_ref_in_pin1_out = ext_ref_in_pin1_ff; // see R7
  assign general_pin_0_out = pin0_val_ff;
  assign general_pin_0_oe_n_out = !pin0_drive_ff; // see R9
  assign general_pin_1_out = pin1_val_ff;
  assign general_pin_1_oe_n_out = !pin1_drive_ff; // see R8
  assign elem_count_out = elem_count_ff;

  ////////////////////////////////////////////////////////////////////////////////
  mcr_chop_gen mcr_chop_gen_inst (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .chop_mode_in(chop_mode_ff),
    .conv_start_in(conv_start_in),
    .elem_done_in(elem_done_in),
    .chop_state_out(chop_state_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  a_pump_force_on: assert property (@(posedge clk_in) disable iff (srst_in) // see R4
    pump_force_on_ff |=> pump_enable_out)
    else $error("pump off despite force-on");
  a_pump_both: assert property (@(posedge clk_in) disable iff (srst_in) // see R4
    (pump_force_on_ff && pump_force_off_ff) |=> pump_enable_out)
    else $error("force-off won over force-on");
  a_pump_force_off: assert property (@(posedge clk_in) disable iff (srst_in) // see R5
    (pump_force_off_ff && !pump_force_on_ff) |=> !pump_enable_out)
    else $error("pump on despite force-off");
  a_pin0_gated: assert property (@(posedge clk_in) disable iff (srst_in) // see R9
    ref_out_on_pin0_ff |=> general_pin_0_oe_n_out)
    else $error("pin 0 driven while reference output enabled");
  a_pin1_gated: assert property (@(posedge clk_in) disable iff (srst_in) // see R8
    ext_ref_in_pin1_ff |=> general_pin_1_oe_n_out)
    else $error("pin 1 driven while external reference enabled");
  a_pin0_drive: assert property (@(posedge clk_in) disable iff (srst_in) // see R9
    (pin0_direction_in && !ref_out_on_pin0_ff) |=> !general_pin_0_oe_n_out &&
      general_pin_0_out == $past(pin0_output_value_in))
    else $error("pin 0 not driven with written value");
  a_pin1_drive: assert property (@(posedge clk_in) disable iff (srst_in) // see R8
    (pin1_direction_in && !ext_ref_in_pin1_ff) |=> !general_pin_1_oe_n_out &&
      general_pin_1_out == $past(pin1_output_value_in))
    else $error("pin 1 not driven with written value");
  a_chop_write: assert property (@(posedge clk_in) disable iff (srst_in) // see R3
    wr_mode |=> chop_mode_ff == $past(wdata_chop))
    else $error("chop field not written");
  a_force_on_write: assert property (@(posedge clk_in) disable iff (srst_in) // see R4
    wr_mode |=> pump_force_on_ff == $past(wdata_force_on))
    else $error("force-on bit not written");
  a_force_off_write: assert property (@(posedge clk_in) disable iff (srst_in) // see R5
    wr_mode |=> pump_force_off_ff == $past(wdata_force_off))
    else $error("force-off bit not written");
  a_ref_out_write: assert property (@(posedge clk_in) disable iff (srst_in) // see R6
    wr_mode |=> ref_out_on_pin0_out == $past(reg_wdata_in[MCR_REF_OUT_BIT]))
    else $error("reference output bit not written");
  a_ext_ref_write: assert property (@(posedge clk_in) disable iff (srst_in) // see R7
    wr_mode |=> ext_ref_in_pin1_out == $past(reg_wdata_in[MCR_EXT_REF_BIT]))
    else $error("external reference bit not written");
  a_hold_no_write: assert property (@(posedge clk_in) disable iff (srst_in) // see R11
    !wr_mode |=> $stable(mode_image))
    else $error("register changed without a write");
  a_rsvd_read: assert property (@(posedge clk_in) disable iff (srst_in) // see R11
    sel_mode |-> reg_rdata_out[MCR_RSVD_HI:MCR_RSVD_LO] == MCR_RSVD_VALUE)
    else $error("reserved bits read wrong");
  a_unmapped_read: assert property (@(posedge clk_in) disable iff (srst_in) // see R11
    !sel_mode |-> reg_rdata_out == 8'h00 && !reg_hit_out)
    else $error("unmapped address answered");
  a_elem_count: assert property (@(posedge clk_in) disable iff (srst_in) // see R10
    1'b1 |=> elem_count_out == (4'h1 << $past(elem_count_exponent_in)))
    else $error("elementary count wrong");
  a_elem_count_onehot: assert property (@(posedge clk_in) disable iff (srst_in) // see R10
    $onehot(elem_count_out))
    else $error("elementary count not a power of two");
  // no disable here: these watch the cycle after a reset edge
  a_reset_values: assert property (@(posedge clk_in) // see R5
    srst_in |=> mode_image == {MCR_RSVD_VALUE, MCR_CHOP_RESET, MCR_FORCE_ON_RESET, MCR_FORCE_OFF_RESET,
      MCR_REF_OUT_RESET, MCR_EXT_REF_RESET})
    else $error("register image wrong after reset");
  a_reset_outputs: assert property (@(posedge clk_in) // see R5 R8 R9
    srst_in |=> !pump_enable_out && general_pin_0_oe_n_out && general_pin_1_oe_n_out &&
      elem_count_out == MCR_ELEM_CNT_RESET)
    else $error("outputs wrong after reset");
  c_both_forces: cover property (@(posedge clk_in) pump_force_on_ff && pump_force_off_ff);
  c_mode_write: cover property (@(posedge clk_in) wr_mode);
  c_ext_ref: cover property (@(posedge clk_in) ext_ref_in_pin1_ff && pin1_direction_in);
endmodule

/* dv/test_mcr_mode_ctrl.sv */
// test_mcr_mode_ctrl: self-checking bench for the mode control register
`timescale 1ns/1ps
module test_mcr_mode_ctrl
  import mcr_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr = 8'h70;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic [1:0] expo = 2'h0;
  logic start = 1'b0;
  logic done = 1'b0;
  logic dir0 = 1'b0;
  logic dir1 = 1'b0;
  logic val0 = 1'b0;
  logic val1 = 1'b0;
  logic [7:0] rdata;
  logic hit, p0, p0_oe_n, p1, p1_oe_n, pump, ref_out, ext_ref, chop;
  logic [3:0] count;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  mcr_mode_ctrl mcr_mode_ctrl_inst (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .elem_count_exponent_in(expo), .conv_start_in(start), .elem_done_in(done),
    .pin0_direction_in(dir0), .pin1_direction_in(dir1), .pin0_output_value_in(val0),
    .pin1_output_value_in(val1), .general_pin_0_out(p0), .general_pin_0_oe_n_out(p0_oe_n),
    .general_pin_1_out(p1), .general_pin_1_oe_n_out(p1_oe_n), .pump_enable_out(pump),
    .ref_out_on_pin0_out(ref_out), .ext_ref_in_pin1_out(ext_ref), .chop_state_out(chop),
    .elem_count_out(count));
  always #2.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang is cut short well past the 85 or so cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write, then let the register and its delayed outputs settle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    addr = MCR_MODE_OFFSET;
    tick();
    tick();
  endtask
  task automatic pulse(input bit is_start);
    if (is_start) start = 1'b1;
    else done = 1'b1;
    tick();
    start = 1'b0;
    done = 1'b0;
    tick();
    tick();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("rdata", rdata, 8'h84);
    check("hit", {7'h00, hit}, 8'h01);
    check("pump", {7'h00, pump}, 8'h00);
    check("oe_n", {6'h00, p1_oe_n, p0_oe_n}, 8'h03);
    check("chop", {7'h00, chop}, 8'h00);
  endtask
  task automatic t_map();
    addr = 8'h71;
    tick();
    check("rdata unmapped", rdata, 8'h00);
    check("hit unmapped", {7'h00, hit}, 8'h00);
    wr_reg(8'h71, 8'h08);
    check("rdata after stray", rdata, 8'h84);
    check("pump after stray", {7'h00, pump}, 8'h00);
  endtask
  task automatic t_pump();
    wr_reg(MCR_MODE_OFFSET, 8'h0C);
    check("pump both", {7'h00, pump}, 8'h01);
    wr_reg(MCR_MODE_OFFSET, 8'h04);
    check("pump off", {7'h00, pump}, 8'h00);
    wr_reg(MCR_MODE_OFFSET, 8'hFF);
    check("rdata all", rdata, 8'hBF);
    wr_reg(MCR_MODE_OFFSET, 8'h00);
    check("rdata none", rdata, 8'h80);
    check("pump none", {7'h00, pump}, 8'h01);
  endtask
  task automatic t_pins();
    dir0 = 1'b1;
    dir1 = 1'b1;
    val0 = 1'b1;
    val1 = 1'b1;
    wr_reg(MCR_MODE_OFFSET, 8'h00);
    check("pins plain", {4'h0, p1, p1_oe_n, p0, p0_oe_n}, 8'h0A);
    wr_reg(MCR_MODE_OFFSET, 8'h02);
    check("ref out", {5'h00, ref_out, p1_oe_n, p0_oe_n}, 8'h05);
    wr_reg(MCR_MODE_OFFSET, 8'h01);
    check("ext ref", {5'h00, ext_ref, p1_oe_n, p0_oe_n}, 8'h06);
    val0 = 1'b0;
    val1 = 1'b0;
    dir1 = 1'b0;
    wr_reg(MCR_MODE_OFFSET, 8'h00);
    check("pins dir", {4'h0, p1, p1_oe_n, p0, p0_oe_n}, 8'h04);
  endtask
  // the toggling modes restart at 0 on every conversion start
  task automatic t_chop();
    wr_reg(MCR_MODE_OFFSET, 8'h10);
    check("chop high", {7'h00, chop}, 8'h01);
    wr_reg(MCR_MODE_OFFSET, 8'h20);
    pulse(1'b1);
    check("chop each start", {7'h00, chop}, 8'h00);
    for (int i = 1; i <= 4; i++) begin
      pulse(1'b0);
      check("chop each", {7'h00, chop}, 8'(i & 1));
    end
    wr_reg(MCR_MODE_OFFSET, 8'h30);
    pulse(1'b1);
    for (int i = 1; i <= 4; i++) begin
      pulse(1'b0);
      check("chop half", {7'h00, chop}, 8'((i >> 1) & 1));
    end
  endtask
  task automatic t_count();
    for (int e = 0; e < 4; e++) begin
      expo = 2'(e);
      tick();
      tick();
      check("elem count", {4'h0, count}, 8'(1 << e));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) tick();
    srst_in = 1'b0;
    t_reset();
    t_map();
    t_pump();
    t_pins();
    t_chop();
    t_count();
    close_out();
  end
endmodule
